// ### vic_pkg.sv
// What this block does
// RULE1: Timer group register bits 7..4 hold four timer match request flags.
// RULE2: Timer group register bits 3..0 hold matching enables; all eight read/write, reset zero.
// RULE3: Serial register holds serial1 flag at bit 5, serial0 flag at bit 4.
// RULE4: Serial register holds serial1 enable at bit 1, serial0 enable at bit 0.
// RULE5: Serial register bits 7, 6, 3, 2 read zero and ignore writes.
// RULE6: A source event sets its request flag regardless of its enable.
// RULE7: A set flag vectors only when its enable bit is one.
// RULE8: Global enable at zero blocks every interrupt.
// RULE9: On acceptance next address is pushed, then the vector is loaded.
// RULE10: Return from interrupt pops the saved address to resume execution.
// RULE11: Servicing an interrupt clears the global enable automatically.
// RULE12: Requests during service still set and hold flags, taken later.
// RULE13: Software sets the global enable inside a routine to allow nesting.
// RULE14: No request is acknowledged while the stack is full.
// RULE15: Any set request flag wakes the device from sleep or idle.
// RULE16: Simultaneous requests resolve by fixed priority across vectors.
// RULE17: Vectors: pin 1 08h, comparator 1 10h, group 0 14h, group 1 18h.
// RULE18: Vectors: pin 2 30h, pin 3 34h, group 4 38h, group 5 3ch.
// RULE19: Service clears group and individual flags, never group sub-source flags.
// RULE20: A group flag sets when any of its sub-source flags becomes set.
// RULE21: Sub-source vectors only with own, group and global enables set.
// RULE22: Lowest vector address wins among simultaneous requests.
package vic_pkg;

  localparam int          VIC_PC_W        = 13;
  localparam int          VIC_STACK_DEPTH = 8;
  localparam int          VIC_SP_W        = 4;
  localparam int          VIC_NSRC        = 8;

  // Register byte offsets
  localparam logic [11:0] VIC_OFS_CTRL    = 12'h000;
  localparam logic [11:0] VIC_OFS_FLAGS   = 12'h004;
  localparam logic [11:0] VIC_OFS_TMR     = 12'h008;
  localparam logic [11:0] VIC_OFS_SER     = 12'h00c;
  localparam logic [11:0] VIC_OFS_STAT    = 12'h010;

  // Control register fields, reset values and serial write mask
  localparam int          VIC_CTRL_GIE    = 0;
  localparam int          VIC_CTRL_EN_LSB = 1;
  localparam logic [8:0]  VIC_CTRL_RST    = 9'h000;
  localparam logic [7:0]  VIC_FLAGS_RST   = 8'h00;
  localparam logic [7:0]  VIC_TMR_RST     = 8'h00;
  localparam logic [7:0]  VIC_SER_RST     = 8'h00;
  localparam logic [7:0]  VIC_SER_MASK    = 8'h33;

  // Status register fields
  localparam int          VIC_STAT_FULL   = 0;
  localparam int          VIC_STAT_WAKE   = 1;
  localparam int          VIC_STAT_SP_LSB = 4;
  localparam int          VIC_STAT_VEC_LSB = 8;

  // Source index, lowest index is highest priority
  localparam int          VIC_SRC_EXT1    = 0;
  localparam int          VIC_SRC_CMP1    = 1;
  localparam int          VIC_SRC_GRP0    = 2;
  localparam int          VIC_SRC_GRP1    = 3;
  localparam int          VIC_SRC_EXT2    = 4;
  localparam int          VIC_SRC_EXT3    = 5;
  localparam int          VIC_SRC_GRP4    = 6;
  localparam int          VIC_SRC_GRP5    = 7;

  localparam logic [7:0]  VIC_VEC_EXT1    = 8'h08;
  localparam logic [7:0]  VIC_VEC_CMP1    = 8'h10;
  localparam logic [7:0]  VIC_VEC_GRP0    = 8'h14;
  localparam logic [7:0]  VIC_VEC_GRP1    = 8'h18;
  localparam logic [7:0]  VIC_VEC_EXT2    = 8'h30;
  localparam logic [7:0]  VIC_VEC_EXT3    = 8'h34;
  localparam logic [7:0]  VIC_VEC_GRP4    = 8'h38;
  localparam logic [7:0]  VIC_VEC_GRP5    = 8'h3c;

  typedef struct packed {
    logic ext_pin1;
    logic comparator1;
    logic group0_src;
    logic group1_src;
    logic ext_pin2;
    logic ext_pin3;
    logic std_timer2_match_a;
    logic std_timer2_match_p;
    logic per_timer3_match_a;
    logic per_timer3_match_p;
    logic serial1;
    logic serial0;
  } vic_events_t;

  typedef struct packed {
    logic                boundary;
    logic                call_push;
    logic                ret_pop;
    logic [VIC_PC_W-1:0] next_pc;
  } vic_core_in_t;

  typedef struct packed {
    logic                pc_load;
    logic [VIC_PC_W-1:0] pc_load_addr;
    logic                ret_valid;
    logic [VIC_PC_W-1:0] ret_addr;
    logic                stack_full;
    logic                wake;
  } vic_core_out_t;

  typedef struct packed {
    logic [8:0]                               ctrl;
    logic [VIC_NSRC-1:0]                      flags;
    logic [7:0]                               tmr;
    logic [7:0]                               ser;
    logic [VIC_SP_W-1:0]                      sp;
    logic [VIC_STACK_DEPTH-1:0][VIC_PC_W-1:0] stack;
    logic [7:0]                               last_vec;
    logic                                     pc_load;
    logic [VIC_PC_W-1:0]                      pc_load_addr;
    logic                                     ret_valid;
    logic [VIC_PC_W-1:0]                      ret_addr;
    logic [31:0]                              prdata;
  } vic_state_t;

endpackage

// ### vic_top.sv
`timescale 1ns/1ps
`default_nettype none
module vic_top
  import vic_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          nrst,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire vic_events_t   events,
  input  wire vic_core_in_t  core_in,
  output vic_core_out_t      core_out
);

  function automatic logic [7:0] vec_of(input logic [2:0] idx);
    case (idx)
      3'h0:    vec_of = VIC_VEC_EXT1;
      3'h1:    vec_of = VIC_VEC_CMP1;
      3'h2:    vec_of = VIC_VEC_GRP0;
      3'h3:    vec_of = VIC_VEC_GRP1;
      3'h4:    vec_of = VIC_VEC_EXT2;
      3'h5:    vec_of = VIC_VEC_EXT3;
      3'h6:    vec_of = VIC_VEC_GRP4;
      default: vec_of = VIC_VEC_GRP5;
    endcase
  endfunction

  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a == VIC_OFS_CTRL) || (a == VIC_OFS_FLAGS) || (a == VIC_OFS_TMR)
           || (a == VIC_OFS_SER) || (a == VIC_OFS_STAT);
  endfunction

  logic       rst_meta_ff;
  logic       rst_sync_n_ff;
  vic_state_t s_ff;
  vic_state_t nxt_s;

  // Reset released through two flops
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_ff   <= 1'b0;
      rst_sync_n_ff <= 1'b0;
    end else begin
      rst_meta_ff   <= 1'b1;
      rst_sync_n_ff <= rst_meta_ff;
    end
  end

  logic                wr;
  logic                full;
  logic                wake;
  logic [VIC_NSRC-1:0] ind_set;
  logic [VIC_NSRC-1:0] ind_en;
  logic [VIC_NSRC-1:0] req;
  logic [VIC_NSRC-1:0] clr;
  logic [3:0]          tm_set;
  logic [1:0]          ser_set;
  logic [7:0]          tmr_w;
  logic [7:0]          ser_w;
  logic [VIC_NSRC-1:0] flags_w;
  logic [2:0]          sel;
  logic                take;
  logic                g4_live;
  logic                g5_live;
  logic [31:0]         rd;

  always_comb begin
    nxt_s     = s_ff;
    wr        = psel && penable && pwrite && addr_ok(paddr);
    full      = (s_ff.sp == VIC_SP_W'(VIC_STACK_DEPTH));
    nxt_s.pc_load   = 1'b0;
    nxt_s.ret_valid = 1'b0;

    // RULE6: events set flags unconditionally
    tm_set  = {events.std_timer2_match_a, events.std_timer2_match_p,
               events.per_timer3_match_a, events.per_timer3_match_p};
    ser_set = {events.serial1, events.serial0};

    // RULE1: timer flags in 7..4; RULE2: enables in 3..0
    tmr_w = (wr && paddr == VIC_OFS_TMR) ? pwdata[7:0] : s_ff.tmr;
    tmr_w[7:4] = tmr_w[7:4] | tm_set;
    // RULE3: serial flags 5,4; RULE4: enables 1,0; RULE5: others stay zero
    ser_w = (wr && paddr == VIC_OFS_SER) ? (pwdata[7:0] & VIC_SER_MASK) : s_ff.ser;
    ser_w[5:4] = ser_w[5:4] | ser_set;
    nxt_s.tmr = tmr_w;
    nxt_s.ser = ser_w;

    if (wr && paddr == VIC_OFS_CTRL) begin
      nxt_s.ctrl = pwdata[8:0];
    end

    // RULE20: group flag follows any newly set sub-source flag
    // Sub enables gate only the vectoring path, not the group flag
    ind_set = '0;
    ind_set[VIC_SRC_EXT1] = events.ext_pin1;
    ind_set[VIC_SRC_CMP1] = events.comparator1;
    ind_set[VIC_SRC_GRP0] = events.group0_src;
    ind_set[VIC_SRC_GRP1] = events.group1_src;
    ind_set[VIC_SRC_EXT2] = events.ext_pin2;
    ind_set[VIC_SRC_EXT3] = events.ext_pin3;
    ind_set[VIC_SRC_GRP4] = |(tmr_w[7:4] & ~s_ff.tmr[7:4]);
    ind_set[VIC_SRC_GRP5] = |(ser_w[5:4] & ~s_ff.ser[5:4]);

    // RULE21: sub-source needs own, group and global enables
    g4_live = |(s_ff.tmr[7:4] & s_ff.tmr[3:0]);
    g5_live = |(s_ff.ser[5:4] & s_ff.ser[1:0]);

    // RULE7: flag vectors only with its enable
    ind_en = s_ff.ctrl[VIC_CTRL_EN_LSB +: VIC_NSRC];
    req    = s_ff.flags & ind_en;
    req[VIC_SRC_GRP4] = req[VIC_SRC_GRP4] & g4_live;
    req[VIC_SRC_GRP5] = req[VIC_SRC_GRP5] & g5_live;
    // RULE8: global enable gates every request
    req = req & {VIC_NSRC{s_ff.ctrl[VIC_CTRL_GIE]}};

    // RULE16: fixed priority; RULE22: lowest vector first
    sel = 3'h0;
    for (int i = VIC_NSRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        sel = 3'(i);
      end
    end

    // RULE14: no acknowledge while stack full; pop same cycle defers take
    take = core_in.boundary && (|req) && !full && !core_in.ret_pop;

    clr = '0;
    if (take) begin
      clr[sel] = 1'b1;
    end

    // RULE19: only top-level flags clear on service
    // RULE12: set wins over clear so new requests are held
    flags_w = (wr && paddr == VIC_OFS_FLAGS) ? pwdata[7:0] : s_ff.flags;
    nxt_s.flags = (flags_w & ~clr) | ind_set;

    if (take) begin
      // RULE9: push next address then load vector
      nxt_s.stack[s_ff.sp[2:0]] = core_in.next_pc;
      nxt_s.sp                  = s_ff.sp + VIC_SP_W'(1);
      nxt_s.pc_load             = 1'b1;
      // RULE17: vectors of first bank; RULE18: vectors of second bank
      nxt_s.pc_load_addr        = VIC_PC_W'(vec_of(sel));
      nxt_s.last_vec            = vec_of(sel);
      // RULE11: service clears global enable, overriding a write
      nxt_s.ctrl[VIC_CTRL_GIE]  = 1'b0;
    end else if (core_in.call_push && !full) begin
      nxt_s.stack[s_ff.sp[2:0]] = core_in.next_pc;
      nxt_s.sp                  = s_ff.sp + VIC_SP_W'(1);
    end else if (core_in.ret_pop && s_ff.sp != '0) begin
      // RULE10: return pops saved address
      nxt_s.ret_addr  = s_ff.stack[3'(s_ff.sp - VIC_SP_W'(1))];
      nxt_s.ret_valid = 1'b1;
      nxt_s.sp        = s_ff.sp - VIC_SP_W'(1);
    end

    // RULE15: any set flag requests wake
    wake = (|s_ff.flags) || (|s_ff.tmr[7:4]) || (|s_ff.ser[5:4]);

    rd = 32'h0000_0000;
    case (paddr)
      VIC_OFS_CTRL:  rd[8:0] = s_ff.ctrl;
      VIC_OFS_FLAGS: rd[7:0] = s_ff.flags;
      VIC_OFS_TMR:   rd[7:0] = s_ff.tmr;
      VIC_OFS_SER:   rd[7:0] = s_ff.ser;
      VIC_OFS_STAT: begin
        rd[VIC_STAT_FULL]                = full;
        rd[VIC_STAT_WAKE]                = wake;
        rd[VIC_STAT_SP_LSB +: VIC_SP_W]  = s_ff.sp;
        rd[VIC_STAT_VEC_LSB +: 8]        = s_ff.last_vec;
      end
      default:       rd = 32'h0000_0000;
    endcase
    // Data captured in setup so prdata is a flop by the access phase
    if (psel && !penable) begin
      nxt_s.prdata = rd;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      s_ff              <= '0;
      s_ff.ctrl         <= VIC_CTRL_RST;
      s_ff.flags        <= VIC_FLAGS_RST;
      s_ff.tmr          <= VIC_TMR_RST;
      s_ff.ser          <= VIC_SER_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign prdata              = s_ff.prdata;
  assign pready              = psel && penable;
  assign pslverr             = psel && penable && !addr_ok(paddr);
  assign core_out.pc_load      = s_ff.pc_load;
  assign core_out.pc_load_addr = s_ff.pc_load_addr;
  assign core_out.ret_valid    = s_ff.ret_valid;
  assign core_out.ret_addr     = s_ff.ret_addr;
  assign core_out.stack_full   = full;
  assign core_out.wake         = wake;

endmodule
`default_nettype wire

// ### vic_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module vic_asserts
  import vic_pkg::*;
(
  input wire logic          ref_clk,
  input wire logic          nrst,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [11:0]   paddr,
  input wire logic [31:0]   prdata,
  input wire vic_events_t   events,
  input wire vic_core_in_t  core_in,
  input wire vic_core_out_t core_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_vec;
    core_out.pc_load |-> core_out.pc_load_addr inside
      {13'h008, 13'h010, 13'h014, 13'h018, 13'h030, 13'h034, 13'h038, 13'h03c};
  endproperty
  a_vec: assert property (p_vec) else $error("vector out of table");
  property p_bnd;
    core_out.pc_load |-> $past(core_in.boundary) && !$past(core_in.ret_pop);
  endproperty
  a_bnd: assert property (p_bnd) else $error("take off boundary");
  property p_full;
    core_out.stack_full && core_in.boundary |=> !core_out.pc_load;
  endproperty
  a_full: assert property (p_full) else $error("take with full stack");
  property p_gie;
    core_out.pc_load && !(psel && penable && pwrite && paddr == VIC_OFS_CTRL)
      |=> !core_out.pc_load [*2];
  endproperty
  a_gie: assert property (p_gie) else $error("take right after take");
  property p_ret;
    core_out.ret_valid |-> $past(core_in.ret_pop);
  endproperty
  a_ret: assert property (p_ret) else $error("return without pop");
  property p_wake;
    |events[11:6] |=> core_out.wake;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on request");
  property p_ser;
    psel && penable && !pwrite && paddr == VIC_OFS_SER |-> prdata[7:6] == 2'h0
      && prdata[3:2] == 2'h0;
  endproperty
  a_ser: assert property (p_ser) else $error("serial spare bits set");
  property p_once;
    $rose(core_out.pc_load) |=> $fell(core_out.pc_load);
  endproperty
  a_once: assert property (p_once) else $error("long vector pulse");
  c_take: cover property (core_out.pc_load);
  c_full: cover property (core_out.stack_full && core_in.boundary);
  c_ret: cover property (core_out.ret_valid);
endmodule
`default_nettype wire

// ### vic_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module vic_core_model
  import vic_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        slow,
  input  wire logic        pop_req,
  input  wire logic        push_req,
  input  wire logic [12:0] pc,
  output var vic_core_in_t core_in
);
  logic [1:0] div = 2'h0;
  always @(posedge ref_clk) div <= div + 2'h1;
  // Slow core offers a boundary one cycle in four
  assign core_in.boundary = !slow || div == 2'h0;
  assign core_in.call_push = push_req;
  assign core_in.ret_pop = pop_req;
  assign core_in.next_pc = pc;
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import vic_pkg::*;
;
  logic          ref_clk, nrst, psel, penable, pwrite, err, slow, pop_req, push_req;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, rd, lastv, lastr;
  logic          pready, pslverr;
  logic [12:0]   pc;
  vic_events_t   ev;
  vic_core_in_t  core_in;
  vic_core_out_t core_out;
  int            error_cnt, check_count, cyc, nload;
  int            eb[8] = '{11, 10, 9, 8, 7, 6, 5, 0};
  logic [31:0]   vt[8] = '{32'h08, 32'h10, 32'h14, 32'h18, 32'h30, 32'h34, 32'h38, 32'h3c};
  vic_top vic_top_inst(.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .events(ev), .core_in, .core_out);
  vic_core_model vic_core_model_inst(.ref_clk, .slow, .pop_req, .push_req, .pc, .core_in);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (core_out.pc_load === 1'b1) begin
      nload++;
      lastv = 32'(core_out.pc_load_addr);
    end
    if (core_out.ret_valid === 1'b1) lastr = 32'(core_out.ret_addr);
    if (cyc > 6000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Slow boundary may delay a take by three cycles
  task automatic pulse(input int b);
    ev <= vic_events_t'(12'h001 << b);
    @(posedge ref_clk);
    ev <= '0;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic do_pop;
    pop_req <= 1'b1;
    @(posedge ref_clk);
    pop_req <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {nrst, psel, penable, pwrite, slow, pop_req, push_req} = '0;
    {paddr, pwdata, pc, ev} = '0;
    {error_cnt, check_count, cyc, nload} = '0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 5; i++) rdc(12'(4 * i), 32'h0);
    apb(1'b1, VIC_OFS_TMR, 32'hff);
    rdc(VIC_OFS_TMR, 32'hff);
    apb(1'b1, VIC_OFS_SER, 32'hff);
    rdc(VIC_OFS_SER, 32'h33);
    rdc(VIC_OFS_FLAGS, 32'hc0);
    apb(1'b0, 12'h020, 32'h0);
    chk({rd[31:1], err}, 32'h1);
    apb(1'b1, VIC_OFS_TMR, 32'h00);
    apb(1'b1, VIC_OFS_FLAGS, 32'h0);
    // Sub flag set with its own enable off
    apb(1'b1, VIC_OFS_TMR, 32'h48);
    rdc(VIC_OFS_FLAGS, 32'h40);
    apb(1'b1, VIC_OFS_TMR, 32'h08);
    apb(1'b1, VIC_OFS_SER, 32'h01);
    apb(1'b1, VIC_OFS_FLAGS, 32'h0);
    chk(32'(core_out.wake), 32'h0);
    $display("registers done");
    slow <= 1'b1;
    apb(1'b1, VIC_OFS_CTRL, 32'h001);
    pulse(11);
    chk(32'(nload), 32'h0);
    rdc(VIC_OFS_FLAGS, 32'h01);
    chk(32'(core_out.wake), 32'h1);
    apb(1'b1, VIC_OFS_CTRL, 32'h006);
    pulse(10);
    chk(32'(nload), 32'h0);
    rdc(VIC_OFS_FLAGS, 32'h03);
    pc <= 13'h100;
    apb(1'b1, VIC_OFS_CTRL, 32'h007);
    repeat (6) @(posedge ref_clk);
    chk(lastv, 32'h08);
    rdc(VIC_OFS_CTRL, 32'h006);
    rdc(VIC_OFS_FLAGS, 32'h02);
    pc <= 13'h101;
    apb(1'b1, VIC_OFS_CTRL, 32'h007);
    repeat (6) @(posedge ref_clk);
    chk(lastv, 32'h10);
    rdc(VIC_OFS_STAT, 32'h1020);
    do_pop;
    chk(lastr, 32'h101);
    do_pop;
    chk(lastr, 32'h100);
    $display("priority done");
    slow <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      pc <= 13'h200 + 13'(i);
      apb(1'b1, VIC_OFS_CTRL, 32'(2 << i) | 32'h1);
      pulse(eb[i]);
      chk(lastv, vt[i]);
      rdc(VIC_OFS_CTRL, 32'(2 << i));
    end
    chk(32'(core_out.stack_full), 32'h1);
    rdc(VIC_OFS_TMR, 32'h88);
    rdc(VIC_OFS_SER, 32'h11);
    apb(1'b1, VIC_OFS_CTRL, 32'h003);
    pulse(11);
    chk(32'(nload), 32'd10);
    do_pop;
    chk(lastr, 32'h207);
    repeat (4) @(posedge ref_clk);
    chk(32'(nload), 32'd11);
    for (int i = 7; i >= 0; i--) begin
      do_pop;
      chk(lastr, 32'h200 + 32'(i));
    end
    pc <= 13'h123;
    push_req <= 1'b1;
    @(posedge ref_clk);
    push_req <= 1'b0;
    do_pop;
    chk(lastr, 32'h123);
    $display("vectors done");
    final_report();
  end
endmodule
bind vic_top vic_asserts vic_asserts_inst(.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr,
  .prdata, .events, .core_in, .core_out);
`default_nettype wire
